// ### pkg/serial_glue_pkg.sv
// Purpose: Shared constants and carriers for the serial port clock and glue block
// Assumes: 250 MHz system clock; baud clocks are one-cycle enable ticks at 16x rate
// Notes:   Base and character tap divider counts are parameters of the top with these as defaults
package serial_glue_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ       = 250_000_000;
  localparam int unsigned DATA_W         = 7;
  localparam int unsigned RATE_SEL_W     = 4;
  localparam int unsigned FIFO_DEPTH     = 16;
  // Base 16x tick for 19200 baud: 250e6 / (19200*16) rounded down
  localparam int unsigned BASE_DIV       = CLOCK_HZ / (19200 * 16);
  localparam int unsigned DOT_LOW_DIV    = 10;
  localparam int unsigned DOT_QUART_DIV  = 4;
  localparam int unsigned CHAR_POS_DIV32_TAP_DIV      = 32;
  // 1200 baud ticks counted down for the 110 baud clock
  localparam int unsigned LOW110_DIV     = 11;
  localparam logic [DATA_W-1:0] NULL_CODE = 7'h00;

  // ----------------------------------------------------------------
  // Rate selection codes
  // ----------------------------------------------------------------
  localparam logic [RATE_SEL_W-1:0] SEL_75    = 4'h0;
  localparam logic [RATE_SEL_W-1:0] SEL_110   = 4'h1;
  localparam logic [RATE_SEL_W-1:0] SEL_150   = 4'h2;
  localparam logic [RATE_SEL_W-1:0] SEL_300   = 4'h3;
  localparam logic [RATE_SEL_W-1:0] SEL_600   = 4'h4;
  localparam logic [RATE_SEL_W-1:0] SEL_1000  = 4'h5;
  localparam logic [RATE_SEL_W-1:0] SEL_1200  = 4'h6;
  localparam logic [RATE_SEL_W-1:0] SEL_1800  = 4'h7;
  localparam logic [RATE_SEL_W-1:0] SEL_2000  = 4'h8;
  localparam logic [RATE_SEL_W-1:0] SEL_2400  = 4'h9;
  localparam logic [RATE_SEL_W-1:0] SEL_3600  = 4'ha;
  localparam logic [RATE_SEL_W-1:0] SEL_4800  = 4'hb;
  localparam logic [RATE_SEL_W-1:0] SEL_7200  = 4'hc;
  localparam logic [RATE_SEL_W-1:0] SEL_9600  = 4'hd;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic holding_reg_empty;
    logic shifter_empty;
    logic rx_ready;
  } xcvr_status_t;

  typedef struct packed {
    logic              load;
    logic [DATA_W-1:0] data;
  } tx_load_t;

endpackage : serial_glue_pkg

// ### core/char_fifo.sv
// Purpose: Small synchronous FIFO for received characters
// Assumes: Single clock, synchronous active-low reset
// Notes:   Read data come from a register; valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [WIDTH-1:0] dout_q;
  logic             dvalid_q;
  logic             push;
  logic             pop_mem;
  logic             mem_empty;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign mem_empty   = (cnt_q == '0);
  // Occupancy counts the output register too, so capacity is exactly DEPTH
  assign in_ready_o  = ((cnt_q + (AW+1)'(dvalid_q)) != (AW+1)'(DEPTH));
  assign push        = in_valid_i && in_ready_o;
  assign pop_mem     = !mem_empty && (!dvalid_q || out_ready_i);
  assign out_valid_o = dvalid_q;
  assign out_data_o  = dout_q;

  // Storage write
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock_i) begin
    if (!resetn_i || flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop_mem) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop_mem);
    end
  end

  // Registered read stage
  always_ff @(posedge clock_i) begin
    if (!resetn_i || flush_i) begin
      dvalid_q <= 1'b0;
      dout_q   <= '0;
    end else if (pop_mem) begin
      dvalid_q <= 1'b1;
      dout_q   <= mem_q[rd_q];
    end else if (out_ready_i) begin
      dvalid_q <= 1'b0;
    end
  end
endmodule : char_fifo
`default_nettype wire

// ### core/serial_glue.sv
// Purpose: Baud clock generation and transceiver glue for a terminal serial port
// Assumes: Transceiver core outside; its status pins arrive from other logic
// Notes:   Baud clocks are one-cycle ticks at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
module serial_glue #(
  parameter int unsigned BASE_DIV   = serial_glue_pkg::BASE_DIV,
  parameter int unsigned CHAR_POS_DIV32_TAP_DIV  = serial_glue_pkg::CHAR_POS_DIV32_TAP_DIV,
  parameter int unsigned FIFO_DEPTH = serial_glue_pkg::FIFO_DEPTH
) (
  input  wire logic                                    clock_i,
  input  wire logic                                    resetn_i,
  input  wire logic                                    dot_pos_low_tap_i,
  input  wire logic [serial_glue_pkg::RATE_SEL_W-1:0]  rate_switch_i,
  input  wire logic [serial_glue_pkg::RATE_SEL_W-1:0]  printer_jumper_i,
  input  wire logic                                    printing_i,
  output logic                                         baud_tick_o,
  output logic                                         char_pos_div32_tap_o,
  input  wire serial_glue_pkg::xcvr_status_t           xcvr_status_i,
  input  wire logic [serial_glue_pkg::DATA_W-1:0]      rx_data_i,
  output logic                                         data_received_reset_o,
  output logic                                         input_buffer_load_o,
  output logic                                         input_buffer_clear_o,
  input  wire logic                                    prog_buffer_clear_cmd_i,
  input  wire logic                                    op_reg_load_cmd_i,
  input  wire logic                                    mode0_i,
  output logic                                         rx_valid_o,
  input  wire logic                                    rx_ready_i,
  output logic      [serial_glue_pkg::DATA_W-1:0]      rx_char_o,
  input  wire logic [serial_glue_pkg::DATA_W-1:0]      bus_data_i,
  input  wire logic                                    key_tx_load_req_i,
  input  wire logic                                    prog_tx_load_cmd_i,
  input  wire logic                                    system_strobe_i,
  input  wire logic                                    main_clear_to_send_i,
  input  wire logic                                    printer_clear_to_send_i,
  input  wire logic                                    conversation_mode_i,
  output serial_glue_pkg::tx_load_t                    tx_load_o,
  output logic                                         tx_busy_o,
  output logic                                         tx_busy_synced_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       dot_s;
  logic       main_cts_s;
  logic       prn_cts_s;
  logic       strobe_s;

  // Two-stage capture of asynchronous pins
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {system_strobe_i, printer_clear_to_send_i,
                 main_clear_to_send_i, dot_pos_low_tap_i};
      sync_q <= meta_q;
    end
  end
  assign dot_s      = sync_q[0];
  assign main_cts_s = sync_q[1];
  assign prn_cts_s  = sync_q[2];
  assign strobe_s   = sync_q[3];

  // ----------------------------------------------------------------
  // Baud tick chains
  // ----------------------------------------------------------------
  // Next count of a wrapping divider
  function automatic logic [15:0] wrap_next(input logic [15:0] c, input int unsigned m);
    wrap_next = (c == 16'(m - 1)) ? 16'h0000 : c + 16'h0001;
  endfunction

  logic [15:0] base_cnt_q;
  logic [7:0]  bin_q;
  logic [8:0]  bin_tick;
  logic        base_tick;
  logic [15:0] cpc_cnt_q;
  logic        cpc_tick;
  logic        dot_d1_q;
  logic        dot_rise;
  logic [15:0] dec_cnt_q;
  logic [1:0]  quart_q;
  logic [1:0]  low_q;
  logic        t7200;
  logic [2:0]  low_tick;
  logic [15:0] c110_q;
  logic        t110;

  assign base_tick = (base_cnt_q == 16'(BASE_DIV - 1));
  assign cpc_tick  = (cpc_cnt_q == 16'(CHAR_POS_DIV32_TAP_DIV - 1));
  assign dot_rise  = dot_s && !dot_d1_q;
  assign t7200     = dot_rise && (dec_cnt_q == 16'(serial_glue_pkg::DOT_LOW_DIV - 1))
                     && (quart_q == 2'(serial_glue_pkg::DOT_QUART_DIV - 1));

  // Binary halving stage ticks: bin_tick[k] is 19200 >> k
  always_comb begin
    bin_tick[0] = base_tick;
    for (int k = 1; k < 9; k++) begin
      bin_tick[k] = bin_tick[k-1] && bin_q[k-1];
    end
  end

  // Base divider and eight halvings, 19200 down to 75
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      base_cnt_q <= 16'h0000;
      bin_q      <= 8'h00;
    end else begin
      base_cnt_q <= wrap_next(base_cnt_q, BASE_DIV);
      for (int k = 0; k < 8; k++) begin
        if (bin_tick[k]) bin_q[k] <= !bin_q[k];
      end
    end
  end

  // Character counter divide-by-32 tap, used directly for 2000
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cpc_cnt_q <= 16'h0000;
    end else begin
      cpc_cnt_q <= wrap_next(cpc_cnt_q, CHAR_POS_DIV32_TAP_DIV);
    end
  end

  // Dot tap divided by 10 then 4, then halved twice
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      dot_d1_q  <= 1'b0;
      dec_cnt_q <= 16'h0000;
      quart_q   <= 2'h0;
      low_q     <= 2'h0;
    end else begin
      dot_d1_q <= dot_s;
      if (dot_rise) begin
        dec_cnt_q <= wrap_next(dec_cnt_q, serial_glue_pkg::DOT_LOW_DIV);
        if (dec_cnt_q == 16'(serial_glue_pkg::DOT_LOW_DIV - 1)) quart_q <= quart_q + 2'h1;
      end
      if (low_tick[0]) low_q[0] <= !low_q[0];
      if (low_tick[1]) low_q[1] <= !low_q[1];
    end
  end
  assign low_tick[0] = t7200;
  assign low_tick[1] = low_tick[0] && low_q[0];
  assign low_tick[2] = low_tick[1] && low_q[1];

  // 1200 ticks counted down to 110
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      c110_q <= 16'h0000;
    end else if (bin_tick[4]) begin
      c110_q <= wrap_next(c110_q, serial_glue_pkg::LOW110_DIV);
    end
  end
  assign t110 = bin_tick[4] && (c110_q == 16'(serial_glue_pkg::LOW110_DIV - 1));

  // Rate table lookup from a four-bit position
  function automatic logic pick_rate(input logic [3:0] s, input logic [8:0] b,
                                     input logic [2:0] l, input logic c, input logic e);
    unique case (s)
      serial_glue_pkg::SEL_75:   pick_rate = b[8];
      serial_glue_pkg::SEL_110:  pick_rate = e;
      serial_glue_pkg::SEL_150:  pick_rate = b[7];
      serial_glue_pkg::SEL_300:  pick_rate = b[6];
      serial_glue_pkg::SEL_600:  pick_rate = b[5];
      serial_glue_pkg::SEL_1000: pick_rate = 1'b0; // No source for this rate
      serial_glue_pkg::SEL_1200: pick_rate = b[4];
      serial_glue_pkg::SEL_1800: pick_rate = l[2];
      serial_glue_pkg::SEL_2000: pick_rate = c;
      serial_glue_pkg::SEL_2400: pick_rate = b[3];
      serial_glue_pkg::SEL_3600: pick_rate = l[1];
      serial_glue_pkg::SEL_4800: pick_rate = b[2];
      serial_glue_pkg::SEL_7200: pick_rate = l[0];
      serial_glue_pkg::SEL_9600: pick_rate = b[1];
      default:                   pick_rate = b[0];
    endcase
  endfunction

  logic main_tick;
  logic prn_tick;
  assign main_tick = pick_rate(rate_switch_i, bin_tick, low_tick, cpc_tick, t110);
  assign prn_tick  = pick_rate(printer_jumper_i, bin_tick, low_tick, cpc_tick, t110);

  // Transceiver clock: line rate or printer rate
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      baud_tick_o          <= 1'b0;
      char_pos_div32_tap_o <= 1'b0;
    end else begin
      baud_tick_o          <= printing_i ? prn_tick : main_tick;
      char_pos_div32_tap_o <= cpc_tick;
    end
  end

  // ----------------------------------------------------------------
  // Receive path into the input buffer
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  logic load_q;
  logic clear_q;

  // Load when ready flag high and buffer free; one pulse per character
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      load_q <= 1'b0;
    end else begin
      load_q <= xcvr_status_i.rx_ready && fifo_in_ready && !load_q;
    end
  end
  assign input_buffer_load_o   = load_q;
  assign data_received_reset_o = load_q;

  // Buffer clear from command or mode 0 operation register load
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= prog_buffer_clear_cmd_i || (mode0_i && op_reg_load_cmd_i);
    end
  end
  assign input_buffer_clear_o = clear_q;

  // Received characters held until processed
  char_fifo #(
    .WIDTH (serial_glue_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .flush_i     (clear_q),
    .in_valid_i  (load_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_data_i),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_char_o)
  );

  // ----------------------------------------------------------------
  // Transmit load and busy
  // ----------------------------------------------------------------
  logic window_q;
  logic window_d1_q;
  logic prog_load_q;
  logic bus_null;
  logic busy_sync_q;
  logic cts_sel;

  assign bus_null = (bus_data_i == serial_glue_pkg::NULL_CODE);

  // One-cycle load window from the processor command
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      window_q    <= 1'b0;
      window_d1_q <= 1'b0;
    end else begin
      window_q    <= prog_tx_load_cmd_i && !window_q;
      window_d1_q <= window_q;
    end
  end

  // Load flop set on window rise, dropped by strobe
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      prog_load_q <= 1'b0;
    end else if (window_q && !window_d1_q) begin
      prog_load_q <= 1'b1;
    end else if (strobe_s) begin
      prog_load_q <= 1'b0;
    end
  end

  // Keyboard OR processor load, suppressed on null bus
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_load_o <= '0;
    end else begin
      tx_load_o.load <= (key_tx_load_req_i || prog_load_q) && !bus_null;
      tx_load_o.data <= bus_data_i;
    end
  end

  // Busy from status flags and load in progress
  assign tx_busy_o = !(xcvr_status_i.holding_reg_empty && xcvr_status_i.shifter_empty)
                     || window_q || prog_load_q;

  // Selected clear-to-send; asserted low pins, so high means not clear
  assign cts_sel = printing_i ? prn_cts_s : main_cts_s;

  // Busy latched on system strobe, forced by clear-to-send in conversation mode
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      busy_sync_q <= 1'b0;
    end else if (strobe_s) begin
      busy_sync_q <= tx_busy_o || (conversation_mode_i && cts_sel);
    end
  end
  assign tx_busy_synced_o = busy_sync_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_null_blocks;
    @(posedge clock_i) disable iff (!resetn_i)
      bus_null |=> !tx_load_o.load;
  endproperty
  a_null_blocks: assert property (p_null_blocks) else $error("load on null");

  property p_busy_flags;
    @(posedge clock_i) disable iff (!resetn_i)
      !xcvr_status_i.shifter_empty |-> tx_busy_o;
  endproperty
  a_busy_flags: assert property (p_busy_flags) else $error("busy missing");

  property p_clear;
    @(posedge clock_i) disable iff (!resetn_i)
      prog_buffer_clear_cmd_i |=> input_buffer_clear_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missing");

  property p_mode_clear;
    @(posedge clock_i) disable iff (!resetn_i)
      mode0_i && op_reg_load_cmd_i |=> input_buffer_clear_o ##1 !rx_valid_o;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode clear");

  property p_load_resets;
    @(posedge clock_i) disable iff (!resetn_i)
      input_buffer_load_o |-> data_received_reset_o;
  endproperty
  a_load_resets: assert property (p_load_resets) else $error("no rx reset");

  property p_load_cause;
    @(posedge clock_i) disable iff (!resetn_i)
      $rose(input_buffer_load_o) |-> $past(xcvr_status_i.rx_ready);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("load no ready");

  property p_sync_stable;
    @(posedge clock_i) disable iff (!resetn_i)
      !strobe_s |=> $stable(tx_busy_synced_o);
  endproperty
  a_sync_stable: assert property (p_sync_stable) else $error("sync moved");

  property p_window_one;
    @(posedge clock_i) disable iff (!resetn_i)
      window_q |=> !window_q;
  endproperty
  a_window_one: assert property (p_window_one) else $error("window long");
endmodule : serial_glue
`default_nettype wire

// ### verification/xcvr_model.sv
// Purpose: Transceiver model on the far side of serial_glue
// Assumes: One clock; the bench raises characters through deliver
// Notes:   Idle data lines show the inverse of the last character
`timescale 1ns/1ps
`default_nettype none
module xcvr_model (
  input  wire logic                          clock_i,
  input  wire logic                          data_received_reset_i,
  input  wire serial_glue_pkg::tx_load_t     tx_load_i,
  output serial_glue_pkg::xcvr_status_t      status_o,
  output logic [serial_glue_pkg::DATA_W-1:0] data_o
);
  logic       ready_q = 1'b0;
  logic       stall_q = 1'b0;
  logic [6:0] char_q  = 7'h00;
  logic [3:0] busy_q  = 4'h0;
  // Status toward the glue; stall keeps the holding register full
  assign status_o.holding_reg_empty = (busy_q == 4'h0) & ~stall_q;
  assign status_o.shifter_empty     = (busy_q == 4'h0);
  assign status_o.rx_ready          = ready_q;
  // Released data lines must not look like the last character
  assign data_o = ready_q ? char_q : ~char_q;
  // Unload drops ready; a load keeps the shifter busy for a while
  always @(posedge clock_i) begin
    if (data_received_reset_i) begin
      ready_q <= 1'b0;
    end
    if (tx_load_i.load) begin
      busy_q <= 4'h8;
    end else if (busy_q != 4'h0) begin
      busy_q <= busy_q - 4'h1;
    end
  end
  // Character complete at the middle of its stop bit
  task automatic deliver(input logic [6:0] c);
    @(negedge clock_i);
    char_q = c;
    ready_q = 1'b1;
  endtask : deliver
endmodule : xcvr_model
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for serial_glue
// Assumes: BASE_DIV 4, CHAR_POS_DIV32_TAP_DIV 4; dot tap rises every 4 cycles
// Notes:   Inputs change on the falling edge; one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clock_i = 1'b0;
  logic       dot     = 1'b0;
  logic       resetn, printing, clr, op, m0, rdy, key, cmd, stb, mcts, pcts, conv;
  logic [3:0] sw, jmp;
  logic [6:0] bus, rx_data, rx_char;
  logic       tick, tap, drr, ld, clr_o, rx_valid, busy, busy_s;
  serial_glue_pkg::xcvr_status_t st;
  serial_glue_pkg::tx_load_t     txl;
  int         n_fail       = 0;
  int         total_checks = 0;
  // Clock and dot counter tap
  always #2 clock_i = ~clock_i;
  always #8 dot = ~dot;
  serial_glue #(.BASE_DIV(4), .CHAR_POS_DIV32_TAP_DIV(4), .FIFO_DEPTH(16)) u_serial_glue (
    .clock_i(clock_i), .resetn_i(resetn), .dot_pos_low_tap_i(dot), .rate_switch_i(sw),
    .printer_jumper_i(jmp), .printing_i(printing), .baud_tick_o(tick),
    .char_pos_div32_tap_o(tap), .xcvr_status_i(st), .rx_data_i(rx_data),
    .data_received_reset_o(drr), .input_buffer_load_o(ld), .input_buffer_clear_o(clr_o),
    .prog_buffer_clear_cmd_i(clr), .op_reg_load_cmd_i(op), .mode0_i(m0),
    .rx_valid_o(rx_valid), .rx_ready_i(rdy), .rx_char_o(rx_char), .bus_data_i(bus),
    .key_tx_load_req_i(key), .prog_tx_load_cmd_i(cmd), .system_strobe_i(stb),
    .main_clear_to_send_i(mcts), .printer_clear_to_send_i(pcts), .conversation_mode_i(conv),
    .tx_load_o(txl), .tx_busy_o(busy), .tx_busy_synced_o(busy_s));
  xcvr_model u_xcvr_model (.clock_i(clock_i), .data_received_reset_i(drr),
    .tx_load_i(txl), .status_o(st), .data_o(rx_data));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task automatic strobe();
    @(negedge clock_i);
    stb = 1'b1;
    @(negedge clock_i);
    stb = 1'b0;
    cyc(4);
  endtask : strobe
  task automatic wait_load();
    for (int k = 0; k < 4 && txl.load !== 1'b1; k++) begin
      @(negedge clock_i);
    end
  endtask : wait_load
  // Tick spacing for every switch position but 1000, then one jumper setting, then 1000 with no tick
  task automatic rates();
    int sel [17] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 13, 5};
    int per [17] = '{1024, 704, 512, 256, 128, 64, 640, 4, 32, 320, 16, 160, 8, 4, 4, 8, 4000};
    int n;
    int t;
    for (int i = 0; i < 17; i++) begin
      @(negedge clock_i);
      printing = (i == 15);
      sw = (i == 15) ? 4'h0 : 4'(sel[i]);
      jmp = 4'(sel[i]);
      n = 0;
      t = 0;
      while (n < 3 && t < 4000) begin
        @(negedge clock_i);
        t++;
        if (tick === 1'b1) begin
          n++;
          if (n < 3) t = 0;
        end
      end
      check(16'(t), 16'(per[i]));
    end
    // Character counter tap: one tick every four cycles
    n = 0;
    repeat (16) begin
      @(negedge clock_i);
      if (tap === 1'b1) n++;
    end
    check(16'(n), 16'h0004);
  endtask : rates
  // Fill the buffer until it refuses, then drain in order
  task automatic rx_fifo();
    for (int i = 0; i < 17; i++) begin
      u_xcvr_model.deliver(7'h41 + 7'(i));
      for (int k = 0; k < 6 && ld !== 1'b1; k++) begin
        @(negedge clock_i);
      end
      check({ld, drr}, {2{i < 16}});
    end
    for (int i = 0; i < 17; i++) begin
      for (int k = 0; k < 8 && rx_valid !== 1'b1; k++) begin
        @(negedge clock_i);
      end
      check(rx_char, 7'h41 + 7'(i));
      rdy = 1'b1;
      @(negedge clock_i);
      rdy = 1'b0;
    end
    cyc(4);
    check(rx_valid, 1'b0);
  endtask : rx_fifo
  // Register load outside mode 0, clear command, mode 0 register load
  task automatic rx_clear();
    logic [2:0] req [3] = '{3'b010, 3'b100, 3'b011};
    for (int i = 0; i < 3; i++) begin
      u_xcvr_model.deliver(7'h60);
      cyc(4);
      {clr, op, m0} = req[i];
      @(negedge clock_i);
      {clr, op, m0} = 3'b000;
      check(clr_o, i != 0);
      cyc(2);
      check(rx_valid, i == 0);
    end
  endtask : rx_clear
  // Keyboard loads; the null character never reaches the transmitter
  task automatic tx_key();
    for (int i = 0; i < 2; i++) begin
      @(negedge clock_i);
      bus = (i == 0) ? 7'h5a : 7'h00;
      key = 1'b1;
      @(negedge clock_i);
      key = 1'b0;
      wait_load();
      check(txl.load, i == 0);
      if (i == 0) check(txl.data, 7'h5a);
      cyc(1);
      check(busy, i == 0);
      cyc(12);
    end
  endtask : tx_key
  // Processor load: busy in the window, load held until the strobe
  task automatic tx_prog();
    @(negedge clock_i);
    bus = 7'h33;
    cmd = 1'b1;
    @(negedge clock_i);
    cmd = 1'b0;
    check(busy, 1'b1);
    wait_load();
    check({txl.load, txl.data}, 8'hb3);
    cyc(3);
    check(txl.load, 1'b1);
    strobe();
    check(txl.load, 1'b0);
  endtask : tx_prog
  // Synced busy follows busy and, in conversation mode, selected clear-to-send only on the strobe
  task automatic busy_sync();
    logic [4:0] cfg [6] = '{5'h00, 5'h10, 5'h0c, 5'h0d, 5'h0b, 5'h03};
    logic [5:0] exp = 6'b010110;
    cyc(12);
    for (int i = 0; i < 6; i++) begin
      {u_xcvr_model.stall_q, conv, mcts, pcts, printing} = cfg[i];
      cyc(4);
      check(busy, cfg[i][4]);
      if (i > 0) check(busy_s, exp[i-1]);
      strobe();
      check(busy_s, exp[i]);
    end
  endtask : busy_sync
  // Watchdog
  initial begin
    #240000;
    n_fail++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {resetn, printing, clr, op, m0, rdy, key, cmd, stb, mcts, pcts, conv} = 12'h000;
    sw = 4'h0;
    jmp = 4'h0;
    bus = 7'h00;
    cyc(4);
    check({ld, clr_o, rx_valid, txl.load, busy_s}, 5'h00);
    resetn = 1'b1;
    rates();
    rx_fifo();
    rx_clear();
    tx_key();
    tx_prog();
    busy_sync();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
